// file: acc_pkg.sv
// constants shared by the converter control block
// Behaviour
// - seven multiplexed inputs, only the selected converts
// - ten-bit unsigned result over two bytes
// - overrange input saturates to all ones
// - underrange input gives all zeros
// - channel field picks the converted input
// - setting converter on starts a conversion
// - convert continuously while converter on
// - completion loads result and sets done flag
// - high read or control write clears done
// - channel change aborts, clears done, restarts
// - clearing converter on stops and powers down
// - wait mode leaves the converter running
// - halt disables; settle interval after wakeup
// - channel code selects inputs in binary order
// - converter clock is cpu/2, cpu or cpu/4
// - high byte bits 9:2, low byte bits 1:0
package acc_pkg;
  localparam int RES_W = 10;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] LAST_INPUT = 3'h6;
  // control and status byte layout
  localparam int CSR_DONE_BIT = 7;
  localparam int CSR_SPEED_BIT = 6;
  localparam int CSR_ON_BIT = 5;
  localparam int CSR_SEL_LSB = 0;
  // low byte layout
  localparam int DRL_SLOW_BIT = 3;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] DRL_RESET = 8'h00;
  // converter clock divider reload values (divisor minus one)
  localparam logic [1:0] DIV_SLOW = 2'h3;
  localparam logic [1:0] DIV_HALF = 2'h1;
  localparam logic [1:0] DIV_FULL = 2'h0;
  // successive approximation timing in converter ticks
  localparam logic [1:0] SAMPLE_TICKS = 2'h2;
  localparam logic [1:0] STEP_TICKS = 2'h3;
  // settling interval after leaving halt
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 12;
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_STEP} acc_sar_e;
  typedef logic [RES_W-1:0] acc_res_t;
endpackage

// file: acc_conv_if.sv
// link between the control logic and the approximation engine
`timescale 1ns/1ps
interface acc_conv_if;
  logic tick;
  logic start;
  logic abort;
  logic comp_high;
  logic busy;
  logic done;
  logic sampling;
  acc_pkg::acc_res_t result;
  acc_pkg::acc_res_t trial;
  modport ctrl (output tick, start, abort, comp_high, input busy, done, sampling, result, trial);
  modport engine (input tick, start, abort, comp_high, output busy, done, sampling, result, trial);
endinterface

// file: acc_clkdiv.sv
// converter clock enable derived from the core clock
`timescale 1ns/1ps
module acc_clkdiv
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic speed,
  output logic tick
);
  import acc_pkg::*;
  logic [1:0] cnt;
  wire [1:0] reload = slow ? DIV_SLOW : (speed ? DIV_FULL : DIV_HALF);
  wire wrap = (cnt == 2'h0);

  // down counter, one tick per wrap
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt <= 2'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= wrap ? reload : cnt - 2'h1;
      tick <= wrap;
    end
  end

  AST_DIV_SLOW: assert property (@(posedge core_clk) disable iff (reset)
    tick && slow && $past(slow) ##1 slow ##1 slow |-> !tick && !$past(tick))
    else $error("slow divider ticked early");
  AST_DIV_FULL: assert property (@(posedge core_clk) disable iff (reset)
    tick && speed && !slow && $past(speed) && !$past(slow) ##1 (speed && !slow)
    ##1 (speed && !slow) |-> tick)
    else $error("full rate divider missed a tick");
endmodule

// file: acc_sar.sv
// successive approximation sequencer, one decision per bit
`timescale 1ns/1ps
module acc_sar
(
  input wire logic core_clk,
  input wire logic reset,
  acc_conv_if.engine conv
);
  import acc_pkg::*;
  acc_sar_e state;
  logic [1:0] ph_cnt;
  logic [3:0] bit_idx;

  function automatic acc_res_t onehot(input logic [3:0] idx);
    onehot = acc_res_t'(10'h001 << idx);
  endfunction

  // phase bookkeeping
  wire ph_last = (state == SAR_SAMPLE) ? (ph_cnt == SAMPLE_TICKS - 2'h1) : (ph_cnt == STEP_TICKS);
  wire step_now = conv.tick && ph_last;
  // keep the tested bit only when the input is at or above the trial
  wire [RES_W-1:0] decided = conv.comp_high ? conv.trial : (conv.trial & ~onehot(bit_idx));
  wire last_bit = (bit_idx == 4'h0);
  wire [RES_W-1:0] next_trial = last_bit ? decided : (decided | onehot(bit_idx - 4'h1));

  // sequencer; abort always wins so a stale result never escapes
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= SAR_IDLE;
      ph_cnt <= 2'h0;
      bit_idx <= 4'h0;
      conv.trial <= '0;
      conv.result <= '0;
      conv.done <= 1'b0;
    end
    else
    begin
      conv.done <= 1'b0;
      if (conv.abort)
        state <= SAR_IDLE;
      else
      begin
        case (state)
          SAR_IDLE:
          begin
            if (conv.start)
            begin
              state <= SAR_SAMPLE;
              ph_cnt <= 2'h0;
              conv.trial <= '0;
            end
          end
          SAR_SAMPLE:
          begin
            if (conv.tick)
              ph_cnt <= step_now ? 2'h0 : ph_cnt + 2'h1;
            if (step_now)
            begin
              state <= SAR_STEP;
              bit_idx <= 4'(RES_W - 1);
              conv.trial <= onehot(4'(RES_W - 1));
            end
          end
          SAR_STEP:
          begin
            if (conv.tick)
              ph_cnt <= step_now ? 2'h0 : ph_cnt + 2'h1;
            if (step_now)
            begin
              conv.trial <= next_trial;
              bit_idx <= bit_idx - 4'h1;
              if (last_bit)
              begin
                state <= SAR_IDLE;
                conv.result <= decided;
                conv.done <= 1'b1;
              end
            end
          end
          default: state <= SAR_IDLE;
        endcase
      end
    end
  end

  assign conv.busy = (state != SAR_IDLE);
  assign conv.sampling = (state == SAR_SAMPLE);

  AST_SAR_ABORT: assert property (@(posedge core_clk) disable iff (reset)
    conv.abort |=> !conv.busy ##1 !conv.done)
    else $error("engine kept running after abort");
endmodule

// file: acc_adc_ctrl.sv
// converter control, result bytes and low power handling
`timescale 1ns/1ps
module acc_adc_ctrl
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic csr_wr_en,
  input wire logic [7:0] csr_wr_data,
  input wire logic drl_wr_en,
  input wire logic [7:0] drl_wr_data,
  input wire logic drh_rd_en,
  input wire logic halt_mode,
  input wire logic comparator_in,
  output logic [7:0] converter_control_status,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte,
  output logic conversion_done,
  output logic converter_powered,
  output logic [acc_pkg::SEL_W-1:0] input_select_out,
  output logic sample_hold,
  output acc_pkg::acc_res_t dac_code
);
  import acc_pkg::*;

  acc_conv_if conv();

  // software visible control state, then internal start, settle and tick state
  logic [SEL_W-1:0] input_select;
  logic converter_on;
  logic speed;
  logic slow;
  logic start_q;
  logic [SETTLE_W-1:0] settle_cnt;
  logic halt_q;
  logic tick;
  // comparator pin synchroniser plus agreement filter
  logic comp_s1;
  logic comp_s2;
  logic comp_s3;
  logic comp_f;

  // converter clock enable
  acc_clkdiv u_div
  (
    .core_clk(core_clk),
    .reset(reset),
    .slow(slow),
    .speed(speed),
    .tick(tick)
  );

  // approximation engine
  acc_sar u_sar
  (
    .core_clk(core_clk),
    .reset(reset),
    .conv(conv.engine)
  );

  // control write decode
  wire [SEL_W-1:0] wr_select = csr_wr_data[CSR_SEL_LSB +: SEL_W];
  wire wr_on = csr_wr_data[CSR_ON_BIT];
  wire sel_change = csr_wr_en && (wr_select != input_select);
  wire switch_off = csr_wr_en && !wr_on;
  // halt powers down; wait has no input here, so it cannot disturb conversion
  wire halt_exit = halt_q && !halt_mode;
  // halt_q also covers the first cycle after wakeup, before the count is loaded
  wire settled = (settle_cnt == '0) && !halt_q;
  wire run_ok = converter_on && !halt_mode && settled;
  // any event that invalidates the conversion in flight
  wire abort_now = sel_change || switch_off || halt_mode || !run_ok;
  wire start_now = run_ok && !abort_now && !conv.busy && !start_q;
  wire good_done = conv.done && !abort_now;
  wire done_clear = drh_rd_en || csr_wr_en;
  // completion beats a same-cycle read, except a channel change, switch off or halt kills it
  wire next_done = good_done ? 1'b1 : (done_clear ? 1'b0 : conversion_done);

  assign conv.tick = tick;
  assign conv.start = start_now;
  assign conv.abort = abort_now;
  // agreed stages pass straight on; the filter flop only bridges a disagreement,
  // which keeps the decision inside a four tick step at full rate
  assign conv.comp_high = (comp_s2 == comp_s3) ? comp_s3 : comp_f;

  // control and configuration registers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      input_select <= CSR_RESET[CSR_SEL_LSB +: SEL_W];
      converter_on <= CSR_RESET[CSR_ON_BIT];
      speed <= CSR_RESET[CSR_SPEED_BIT];
      slow <= DRL_RESET[DRL_SLOW_BIT];
    end
    else
    begin
      if (csr_wr_en)
      begin
        input_select <= wr_select;
        converter_on <= wr_on;
        speed <= csr_wr_data[CSR_SPEED_BIT];
      end
      if (drl_wr_en)
        slow <= drl_wr_data[DRL_SLOW_BIT];
    end
  end

  // start pulse spacing keeps one start per idle engine
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      start_q <= 1'b0;
    else
      start_q <= start_now;
  end

  // settle interval after wakeup; results before it would be inaccurate
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      halt_q <= 1'b0;
      settle_cnt <= '0;
    end
    else
    begin
      halt_q <= halt_mode;
      if (halt_mode)
        settle_cnt <= '0;
      else if (halt_exit)
        settle_cnt <= SETTLE_W'(SETTLE_CYCLES);
      else if (!settled)
        settle_cnt <= settle_cnt - 1'b1;
    end
  end

  // comparator pin: three stages, a change counts when stages two and three agree
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      comp_s3 <= 1'b0;
      comp_f <= 1'b0;
    end
    else
    begin
      comp_s1 <= comparator_in;
      comp_s2 <= comp_s1;
      comp_s3 <= comp_s2;
      if (comp_s2 == comp_s3)
        comp_f <= comp_s3;
    end
  end

  // done flag and result bytes
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      conversion_done <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte <= DRL_RESET;
    end
    else
    begin
      conversion_done <= next_done;
      // a low byte read has no side effect, so it has no strobe at all
      if (good_done)
        result_high_byte <= conv.result[RES_W-1:2];
      result_low_byte <= {4'h0, slow, 1'b0, result_low_byte[1:0]};
      if (good_done)
        result_low_byte[1:0] <= conv.result[1:0];
    end
  end

  // status byte readback; reserved bits stay zero
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      converter_control_status <= CSR_RESET;
    else
    begin
      converter_control_status <= 8'h00;
      converter_control_status[CSR_DONE_BIT] <= next_done;
      converter_control_status[CSR_SPEED_BIT] <= csr_wr_en ? csr_wr_data[CSR_SPEED_BIT] : speed;
      converter_control_status[CSR_ON_BIT] <= csr_wr_en ? wr_on : converter_on;
      converter_control_status[CSR_SEL_LSB +: SEL_W] <= csr_wr_en ? wr_select : input_select;
    end
  end

  // analog side: mux select, power and sample
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      input_select_out <= '0;
      converter_powered <= 1'b0;
      sample_hold <= 1'b0;
    end
    else
    begin
      // codes above the last input are passed on; no such input exists there
      input_select_out <= input_select;
      converter_powered <= converter_on && !halt_mode;
      sample_hold <= conv.sampling;
    end
  end

  // trial flop drives the pin directly; an extra stage would cost the comparator a cycle
  assign dac_code = conv.trial;

  // interrupt request output deliberately absent; the done flag is polled
  wire unused_irq = 1'b0;

  AST_DONE_SET: assert property (@(posedge core_clk) disable iff (reset)
    good_done |=> conversion_done && converter_control_status[CSR_DONE_BIT])
    else $error("done flag not set after completion");

  AST_RESULT_LOAD: assert property (@(posedge core_clk) disable iff (reset)
    good_done |=> {result_high_byte, result_low_byte[1:0]} == $past(conv.result))
    else $error("result bytes do not match the finished conversion");

  AST_HIGH_READ_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    drh_rd_en && !conv.done |=> !conversion_done)
    else $error("high byte read left the done flag set");

  AST_FLAG_HOLDS: assert property (@(posedge core_clk) disable iff (reset)
    conversion_done && !drh_rd_en && !csr_wr_en |=> conversion_done)
    else $error("done flag dropped without a clearing access");

  AST_CHANNEL_ABORT: assert property (@(posedge core_clk) disable iff (reset)
    sel_change && wr_on && !halt_mode && settled |=> !conversion_done ##1 conv.busy)
    else $error("channel change did not restart conversion");

  AST_SWITCH_OFF: assert property (@(posedge core_clk) disable iff (reset)
    switch_off |=> !conv.busy ##1 (!converter_powered && !conv.busy))
    else $error("converter still running after switch off");

  AST_HALT_OFF: assert property (@(posedge core_clk) disable iff (reset)
    halt_mode |=> !converter_powered && !conv.start)
    else $error("converter active during halt");

  AST_SETTLE_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !settled |-> !conv.start && !good_done)
    else $error("conversion ran inside the settle interval");

  AST_CONTINUOUS: assert property (@(posedge core_clk) disable iff (reset)
    good_done && run_ok && !csr_wr_en && !halt_mode |-> ##[1:2] conv.busy)
    else $error("no new conversion after completion");

  AST_ON_START: assert property (@(posedge core_clk) disable iff (reset)
    csr_wr_en && wr_on && !converter_on && !halt_mode && settled |-> ##[2:3] conv.sampling)
    else $error("setting converter on did not start a conversion");

  AST_MUX_FOLLOWS: assert property (@(posedge core_clk) disable iff (reset)
    ##1 input_select_out == $past(input_select))
    else $error("mux select does not follow the channel field");

  AST_LOW_RESERVED: assert property (@(posedge core_clk) disable iff (reset)
    result_low_byte[7:4] == 4'h0 && !result_low_byte[2])
    else $error("reserved low byte bits not zero");
endmodule

// file: acc_analog_model.sv
// analog inputs, input mux and comparator facing the control block
`timescale 1ns/1ps
module acc_analog_model
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [6:0][9:0] levels,
  input wire logic [SEL_W-1:0] input_select_out,
  input wire logic sample_hold,
  input wire logic converter_powered,
  input wire acc_res_t dac_code,
  output logic comparator_in
);
  logic [9:0] held;
  logic idle_bit = 1'b0;
  // sample and hold, so a bit decision never sees a moving level
  always @(posedge core_clk)
  begin
    idle_bit <= ~idle_bit;
    if (sample_hold)
    begin
      held <= levels[input_select_out];
    end
  end
  // unpowered comparator wanders rather than holding its last answer
  assign comparator_in = converter_powered ? (held >= dac_code) : idle_bit;
endmodule

// file: acc_adc_ctrl_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module acc_adc_ctrl_tb_top;
  import acc_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic csr_wr_en = 1'b0;
  logic [7:0] csr_wr_data = 8'h00;
  logic drl_wr_en = 1'b0;
  logic [7:0] drl_wr_data = 8'h00;
  logic drh_rd_en = 1'b0;
  logic halt_mode = 1'b0;
  logic comparator_in;
  logic [7:0] status;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  logic done;
  logic powered;
  logic sample_hold;
  logic [SEL_W-1:0] sel_out;
  acc_res_t dac_code;
  // channel 0 overrange, channel 1 underrange, the rest at assorted levels in between
  logic [6:0][9:0] levels = {10'h155, 10'h2aa, 10'h0f0, 10'h30c, 10'h001, 10'h000, 10'h3ff};
  logic slow_q = 1'b0;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  int p1;
  int p2;
  int p4;

  always #5 core_clk = ~core_clk;

  acc_adc_ctrl dut (.core_clk(core_clk), .reset(reset), .csr_wr_en(csr_wr_en),
    .csr_wr_data(csr_wr_data), .drl_wr_en(drl_wr_en), .drl_wr_data(drl_wr_data),
    .drh_rd_en(drh_rd_en), .halt_mode(halt_mode), .comparator_in(comparator_in),
    .converter_control_status(status), .result_high_byte(high_byte),
    .result_low_byte(low_byte), .conversion_done(done), .converter_powered(powered),
    .input_select_out(sel_out), .sample_hold(sample_hold), .dac_code(dac_code));

  acc_analog_model analog (.core_clk(core_clk), .levels(levels),
    .input_select_out(sel_out), .sample_hold(sample_hold),
    .converter_powered(powered), .dac_code(dac_code), .comparator_in(comparator_in));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the longest expected run
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  function automatic logic [7:0] exp_low(input int ch);
    return {4'h0, slow_q, 1'b0, levels[ch][1:0]};
  endfunction

  task automatic wr_csr(input logic [7:0] d);
    @(posedge core_clk);
    csr_wr_en <= 1'b1;
    csr_wr_data <= d;
    @(posedge core_clk);
    csr_wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd_high();
    @(posedge core_clk);
    drh_rd_en <= 1'b1;
    @(posedge core_clk);
    drh_rd_en <= 1'b0;
    #1;
  endtask

  // bounded wait for the done flag, counting cycles taken
  task automatic wait_done(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    while (done !== 1'b1 && cnt < 1000);
    cmp_bit("done within bound", 1'b1, done);
  endtask

  task automatic t_reset();
    cmp_byte("status at reset", CSR_RESET, status);
    cmp_byte("high at reset", 8'h00, high_byte);
    cmp_byte("low at reset", DRL_RESET, low_byte);
    cmp_bit("powered at reset", 1'b0, powered);
  endtask

  // every input's channel code in turn, each write after the first a channel change
  task automatic t_channels();
    for (int ch = 0; ch < 7; ch++)
    begin
      wr_csr(8'h60 | 8'(ch));
      cmp_byte("status after write", 8'h60 | 8'(ch), status);
      wait_done(n);
      cmp_byte("high byte", levels[ch][9:2], high_byte);
      cmp_byte("low byte", exp_low(ch), low_byte);
      cmp_bit("done in status", 1'b1, status[CSR_DONE_BIT]);
    end
  endtask

  // high read and same-channel write both clear, conversions keep going
  task automatic t_clear();
    rd_high();
    cmp_bit("done after high read", 1'b0, done);
    wait_done(n);
    cmp_byte("high repeated", levels[6][9:2], high_byte);
    wr_csr(8'h66);
    cmp_bit("done after csr write", 1'b0, done);
  endtask

  task automatic t_abort();
    repeat (20) @(posedge core_clk);
    wr_csr(8'h63);
    cmp_bit("done after channel change", 1'b0, done);
    wait_done(n);
    cmp_byte("high new channel", levels[3][9:2], high_byte);
  endtask

  // conversion period at the three clock rates
  task automatic measure(input logic [7:0] csr, input logic slow, output int per);
    @(posedge core_clk);
    drl_wr_en <= 1'b1;
    drl_wr_data <= {4'h0, slow, 3'h0};
    slow_q = slow;
    @(posedge core_clk);
    drl_wr_en <= 1'b0;
    wr_csr(csr);
    wait_done(n);
    rd_high();
    wait_done(per);
    cmp_byte("low with slow", exp_low(5), low_byte);
  endtask

  task automatic t_speed();
    measure(8'h65, 1'b0, p1);
    measure(8'h25, 1'b0, p2);
    measure(8'h65, 1'b1, p4);
    cmp_bit("half rate period", 1'b1, (p2 - p1 >= 38 && p2 - p1 <= 46));
    cmp_bit("quarter rate period", 1'b1, (p4 - p1 >= 118 && p4 - p1 <= 134));
    measure(8'h65, 1'b0, p1);
  endtask

  task automatic t_off();
    wr_csr(8'h03);
    // power follows the on bit one cycle after the register
    @(posedge core_clk);
    #1;
    cmp_bit("powered after off", 1'b0, powered);
    repeat (300) @(posedge core_clk);
    #1;
    cmp_bit("no done while off", 1'b0, done);
  endtask

  // halt powers down, then no sampling until the settle interval is over
  task automatic t_halt();
    wr_csr(8'h63);
    wait_done(n);
    // clear the flag so the wakeup result has to be a fresh one
    rd_high();
    @(posedge core_clk);
    halt_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cmp_bit("powered in halt", 1'b0, powered);
    @(posedge core_clk);
    halt_mode <= 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (sample_hold !== 1'b1 && n < 500);
    cmp_bit("settle respected", 1'b1, (n >= SETTLE_CYCLES && n < 500));
    wait_done(n);
    cmp_byte("high after wakeup", levels[3][9:2], high_byte);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_channels();
    t_clear();
    t_abort();
    t_speed();
    t_off();
    t_halt();
    finish_test();
  end
endmodule
